// >>> verilog/cmpb_pkg.sv
package cmpb_pkg;
    localparam logic [7:0] CMPB_CONTROL_ADDR = 8'h9a;
    localparam logic [7:0] CMPB_MODE_ADDR    = 8'h9c;
    localparam logic [7:0] CMPB_CONTROL_RST  = 8'h00;
    localparam logic [7:0] CMPB_MODE_RST     = 8'h02;
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_OUT_BIT    = 6;
    localparam int CTL_RISE_BIT   = 5;
    localparam int CTL_FALL_BIT   = 4;
    localparam int MD_RISE_IE_BIT = 5;
    localparam int MD_FALL_IE_BIT = 4;
    localparam logic [7:0] MODE_WR_MASK = 8'h33;
    localparam logic [7:0] MODE_RESV_MASK = 8'hcc;
    localparam int CTL_PHYST_LSB  = 2;
    localparam int CTL_NHYST_LSB  = 0;
    localparam int MD_SPEED_LSB   = 0;
endpackage

// >>> verilog/cmpb_ctrl.sv
`timescale 1ns/1ns
// Overview of operation
// RULE1: Mode bit 7 reads zero; software writes zero there.
// RULE2: Mode bit 6 reads zero and ignores writes.
// RULE3: Mode bit 5 enables the rising-edge interrupt.
// RULE4: Mode bit 4 enables the falling-edge interrupt.
// RULE5: Mode bits 3 and 2 read zero and ignore writes.
// RULE6: Mode bits 1 to 0 select response/power, driven to the comparator.
// RULE7: Mode register resets to 0x02.
// RULE8: Control bit 7 enables the comparator.
// RULE9: Control bit 6 is read-only synchronised comparator output.
// RULE10: Control bit 5 sets on each rising output edge until cleared.
// RULE11: Control bit 4 sets on each falling output edge until cleared.
// RULE12: Control bits 3 to 2 give positive hysteresis code to the comparator.
// RULE13: Control bits 1 to 0 give negative hysteresis code to the comparator.
// RULE14: Control register resets to 0x00.
// RULE15: Interrupt request when a flag and its enable are both set.
// RULE16: Comparator output is synchronised before edge detection.
module cmpb_ctrl (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    input  wire logic       cmp_raw_out,
    output logic            cmp_b_enable,
    output logic      [1:0] cmp_b_speed_sel,
    output logic      [1:0] cmp_b_pos_hyst,
    output logic      [1:0] cmp_b_neg_hyst,
    output logic            cmp_b_irq
);
    logic [7:0] mode;
    logic [7:0] next_mode;
    logic       en;
    logic       next_en;
    logic [1:0] pos_hyst;
    logic [1:0] next_pos_hyst;
    logic [1:0] neg_hyst;
    logic [1:0] next_neg_hyst;
    logic       rise_f;
    logic       next_rise_f;
    logic       fall_f;
    logic       next_fall_f;
    logic [2:0] sync;
    logic [2:0] next_sync;
    logic [7:0] next_rdata;
    logic       next_irq;
    logic       next_enable_out;
    logic [1:0] next_speed_out;
    logic [1:0] next_pos_out;
    logic [1:0] next_neg_out;
    logic       wr_ctl;
    logic       wr_md;
    logic       rd_ctl;
    logic       rd_md;
    logic       out_state;
    logic       prev_state;
    logic       rise_ev;
    logic       fall_ev;
    logic [7:0] ctl_view;

    always_comb begin
        wr_ctl = sfr_wr && (sfr_addr == cmpb_pkg::CMPB_CONTROL_ADDR);
        wr_md  = sfr_wr && (sfr_addr == cmpb_pkg::CMPB_MODE_ADDR);
        rd_ctl = sfr_rd && (sfr_addr == cmpb_pkg::CMPB_CONTROL_ADDR);
        rd_md  = sfr_rd && (sfr_addr == cmpb_pkg::CMPB_MODE_ADDR);
    end

    // The chain keeps shifting through reset, so it holds the real level when reset ends.
    always_comb begin
        next_sync  = {sync[1:0], cmp_raw_out}; // RULE16
        out_state  = sync[1];
        prev_state = sync[2];
        rise_ev    = out_state && !prev_state; // RULE16
        fall_ev    = !out_state && prev_state; // RULE16
    end

    always_ff @(posedge mclk) begin
        sync <= next_sync; // RULE16
    end

    always_comb begin
        next_mode = mode;
        if (wr_md) begin
            next_mode = sfr_wdata & cmpb_pkg::MODE_WR_MASK; // RULE1 RULE2 RULE5
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode <= cmpb_pkg::CMPB_MODE_RST; // RULE7
        end else begin
            mode <= next_mode;
        end
    end

    always_comb begin
        next_en       = en;
        next_pos_hyst = pos_hyst;
        next_neg_hyst = neg_hyst;
        if (wr_ctl) begin
            next_en       = sfr_wdata[cmpb_pkg::CTL_ENABLE_BIT]; // RULE8
            next_pos_hyst = sfr_wdata[cmpb_pkg::CTL_PHYST_LSB +: 2]; // RULE12
            next_neg_hyst = sfr_wdata[cmpb_pkg::CTL_NHYST_LSB +: 2]; // RULE13
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            en       <= cmpb_pkg::CMPB_CONTROL_RST[cmpb_pkg::CTL_ENABLE_BIT]; // RULE14
            pos_hyst <= cmpb_pkg::CMPB_CONTROL_RST[cmpb_pkg::CTL_PHYST_LSB +: 2]; // RULE14
            neg_hyst <= cmpb_pkg::CMPB_CONTROL_RST[cmpb_pkg::CTL_NHYST_LSB +: 2]; // RULE14
        end else begin
            en       <= next_en;
            pos_hyst <= next_pos_hyst;
            neg_hyst <= next_neg_hyst;
        end
    end

    // An edge in the same cycle as a software clear wins, so no event is lost.
    always_comb begin
        next_rise_f = rise_f;
        next_fall_f = fall_f;
        if (wr_ctl) begin
            next_rise_f = sfr_wdata[cmpb_pkg::CTL_RISE_BIT];
            next_fall_f = sfr_wdata[cmpb_pkg::CTL_FALL_BIT];
        end
        if (rise_ev) begin
            next_rise_f = 1'b1; // RULE10
        end
        if (fall_ev) begin
            next_fall_f = 1'b1; // RULE11
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rise_f <= cmpb_pkg::CMPB_CONTROL_RST[cmpb_pkg::CTL_RISE_BIT]; // RULE14
            fall_f <= cmpb_pkg::CMPB_CONTROL_RST[cmpb_pkg::CTL_FALL_BIT]; // RULE14
        end else begin
            rise_f <= next_rise_f;
            fall_f <= next_fall_f;
        end
    end

    always_comb begin
        ctl_view = 8'h00;
        ctl_view[cmpb_pkg::CTL_ENABLE_BIT]       = en;
        ctl_view[cmpb_pkg::CTL_OUT_BIT]          = out_state; // RULE9
        ctl_view[cmpb_pkg::CTL_RISE_BIT]         = rise_f;
        ctl_view[cmpb_pkg::CTL_FALL_BIT]         = fall_f;
        ctl_view[cmpb_pkg::CTL_PHYST_LSB +: 2]   = pos_hyst;
        ctl_view[cmpb_pkg::CTL_NHYST_LSB +: 2]   = neg_hyst;
        next_rdata = 8'h00;
        if (rd_ctl) begin
            next_rdata = ctl_view;
        end else if (rd_md) begin
            next_rdata = mode & cmpb_pkg::MODE_WR_MASK; // RULE1 RULE2 RULE5
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= next_rdata;
        end
    end

    always_comb begin
        next_irq = (next_rise_f && next_mode[cmpb_pkg::MD_RISE_IE_BIT]) // RULE3 RULE15
                || (next_fall_f && next_mode[cmpb_pkg::MD_FALL_IE_BIT]); // RULE4 RULE15
        next_enable_out = next_en; // RULE8
        next_speed_out  = next_mode[cmpb_pkg::MD_SPEED_LSB +: 2]; // RULE6
        next_pos_out    = next_pos_hyst; // RULE12
        next_neg_out    = next_neg_hyst; // RULE13
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmp_b_irq       <= 1'b0;
            cmp_b_enable    <= cmpb_pkg::CMPB_CONTROL_RST[cmpb_pkg::CTL_ENABLE_BIT];
            cmp_b_speed_sel <= cmpb_pkg::CMPB_MODE_RST[cmpb_pkg::MD_SPEED_LSB +: 2];
            cmp_b_pos_hyst  <= cmpb_pkg::CMPB_CONTROL_RST[cmpb_pkg::CTL_PHYST_LSB +: 2];
            cmp_b_neg_hyst  <= cmpb_pkg::CMPB_CONTROL_RST[cmpb_pkg::CTL_NHYST_LSB +: 2];
        end else begin
            cmp_b_irq       <= next_irq;
            cmp_b_enable    <= next_enable_out;
            cmp_b_speed_sel <= next_speed_out;
            cmp_b_pos_hyst  <= next_pos_out;
            cmp_b_neg_hyst  <= next_neg_out;
        end
    end

    sequence rise_seen_s;
        out_state && !prev_state;
    endsequence

    sequence fall_seen_s;
        !out_state && prev_state;
    endsequence

    sequence ctl_write_s;
        wr_ctl;
    endsequence

    rise_sets_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
        rise_seen_s |=> rise_f)
        else $error("rise flag not set");

    fall_sets_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
        fall_seen_s |=> fall_f)
        else $error("fall flag not set");

    mode_resv_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
        (mode & cmpb_pkg::MODE_RESV_MASK) == 8'h00)
        else $error("mode reserved bit set");

    irq_match_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE15
        cmp_b_irq == ((rise_f && mode[cmpb_pkg::MD_RISE_IE_BIT])
                   || (fall_f && mode[cmpb_pkg::MD_FALL_IE_BIT])))
        else $error("irq mismatch");

    speed_out_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
        cmp_b_speed_sel == mode[cmpb_pkg::MD_SPEED_LSB +: 2])
        else $error("speed select mismatch");

    enable_out_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
        ctl_write_s |=> cmp_b_enable == $past(sfr_wdata[cmpb_pkg::CTL_ENABLE_BIT]))
        else $error("enable wrong");

    hyst_out_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
        ctl_write_s |=> cmp_b_pos_hyst == $past(sfr_wdata[cmpb_pkg::CTL_PHYST_LSB +: 2]))
        else $error("positive hysteresis wrong");

    neg_hyst_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
        ctl_write_s |=> cmp_b_neg_hyst == $past(sfr_wdata[cmpb_pkg::CTL_NHYST_LSB +: 2]))
        else $error("negative hysteresis wrong");

    out_read_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
        rd_ctl |=> sfr_rdata[cmpb_pkg::CTL_OUT_BIT] == $past(out_state))
        else $error("output state read wrong");

    mode_reset_a: assert property (@(posedge mclk) // RULE7
        !rst_n |=> mode == cmpb_pkg::CMPB_MODE_RST)
        else $error("mode reset wrong");

    speed_reset_a: assert property (@(posedge mclk) // RULE7
        !rst_n |=> cmp_b_speed_sel == cmpb_pkg::CMPB_MODE_RST[cmpb_pkg::MD_SPEED_LSB +: 2])
        else $error("speed select reset wrong");

    ctl_reset_a: assert property (@(posedge mclk) // RULE14
        !rst_n |=> {cmp_b_enable, rise_f, fall_f, cmp_b_pos_hyst, cmp_b_neg_hyst} == 7'h00)
        else $error("control reset wrong");

    rise_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
        (rise_f && !wr_ctl) |=> rise_f)
        else $error("rise flag lost");

    fall_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
        (fall_f && !wr_ctl) |=> fall_f)
        else $error("fall flag lost");

    rise_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
        (wr_ctl && !sfr_wdata[cmpb_pkg::CTL_RISE_BIT] && !rise_ev) |=> !rise_f)
        else $error("rise flag not cleared");

    fall_clear_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
        (wr_ctl && !sfr_wdata[cmpb_pkg::CTL_FALL_BIT] && !fall_ev) |=> !fall_f)
        else $error("fall flag not cleared");

    rise_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE16
        (!rise_ev && !wr_ctl) |=> $stable(rise_f))
        else $error("rise flag changed without edge");

    fall_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE16
        (!fall_ev && !wr_ctl) |=> $stable(fall_f))
        else $error("fall flag changed without edge");

    mode_read_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2 RULE5
        rd_md |=> (sfr_rdata & cmpb_pkg::MODE_RESV_MASK) == 8'h00)
        else $error("mode unused bits read nonzero");

    mode_value_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3 RULE4
        rd_md |=> sfr_rdata == $past(mode))
        else $error("mode read wrong");

    idle_rdata_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
        (sfr_rd && !rd_ctl && !rd_md) |=> sfr_rdata == 8'h00)
        else $error("unmapped read nonzero");

    enable_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
        !wr_ctl |=> $stable(cmp_b_enable))
        else $error("enable changed without write");

    irq_off_a: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3 RULE4
        (!next_mode[cmpb_pkg::MD_RISE_IE_BIT] && !next_mode[cmpb_pkg::MD_FALL_IE_BIT])
        |=> !cmp_b_irq)
        else $error("irq raised while disabled");
endmodule

// >>> tb/test_comparator_one_control.sv
`timescale 1ns/1ns
module test_comparator_one_control;
    logic       mclk        = 1'b0;
    logic       rst_n       = 1'b0;
    logic [7:0] sfr_addr    = 8'h00;
    logic       sfr_wr      = 1'b0;
    logic [7:0] sfr_wdata   = 8'h00;
    logic       sfr_rd      = 1'b0;
    logic       cmp_raw_out = 1'b0;
    logic [7:0] sfr_rdata;
    logic       en;
    logic       irq;
    logic [1:0] spd;
    logic [1:0] ph;
    logic [1:0] nh;
    logic [1:0] c;
    int         num_errors  = 0;
    int         n_checks    = 0;
    wire  [7:0] outs        = {irq, en, spd, ph, nh};
    always #50 mclk = ~mclk;
    cmpb_ctrl cmpb_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .cmp_raw_out(cmp_raw_out), .cmp_b_enable(en), .cmp_b_speed_sel(spd),
        .cmp_b_pos_hyst(ph), .cmp_b_neg_hyst(nh), .cmp_b_irq(irq));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge mclk);
        sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        #1 chk("sfr_rdata", exp, sfr_rdata);
    endtask
    task automatic raw(input logic v);
        @(posedge mclk);
        cmp_raw_out <= v;
        repeat (5) @(posedge mclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'h9a, 8'h00);
        rd(8'h9c, 8'h02);
        chk("outputs", 8'h20, outs);
        $display("test reset values done");
        wr(8'h9c, 8'h7f);
        rd(8'h9c, 8'h33);
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr(8'h9c, {6'h00, c});
            chk("outputs", {2'b00, c, 4'h0}, outs);
        end
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr(8'h9a, {4'h8, c, ~c});
            chk("outputs", {4'h7, c, ~c}, outs);
        end
        wr(8'h9a, 8'hc0);
        rd(8'h9a, 8'h80);
        $display("test register fields done");
        wr(8'h9c, 8'h20);
        raw(1'b1);
        rd(8'h9a, 8'he0);
        chk("outputs", 8'hc0, outs);
        wr(8'h9a, 8'h80);
        chk("outputs", 8'h40, outs);
        raw(1'b0);
        rd(8'h9a, 8'h90);
        chk("outputs", 8'h40, outs);
        wr(8'h9c, 8'h10);
        chk("outputs", 8'hc0, outs);
        rd(8'h9b, 8'h00);
        $display("test edge flags done");
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'h9a, 8'h00);
        rd(8'h9c, 8'h02);
        chk("outputs", 8'h20, outs);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule
